// ### include/vje_pkg.sv
/*
 vje_pkg: constants for the vertical sync jitter elimination and field decision block.
 assumes a 10 MHz clock, classic wishbone with 32-bit data and byte addresses.
*/
// Operation
// - the falling edges of vertical and horizontal sync are compared, and a vertical edge within a quarter line of the horizontal edge is snapped to a stable position.
// - jitter elimination runs only while the enable bit at bit two of the jitter control register is one.
// - the automatic field decision bit turns automatic field decision on at one and off at zero.
// - the field status flag reads one in the field of the first dot row and zero in the field of the second.
// - a three-bit read-only phase flag gives the measured horizontal-to-vertical phase step zero to seven.
// - field line decision signals are derived from the corrected internal horizontal and vertical syncs; the field flag uses the raw vertical edge position.
// - with elimination, auto field and source select all one, both dot rows are displayed.
// - with elimination on and auto field and source select clear, only the second dot row field is displayed.
// - a polarity select bit chooses which horizontal input edge counts as active.
package vje_pkg;
	localparam logic [11:0] VJE_ADDR_CONTROL   = 12'h0fe4;
	localparam logic [11:0] VJE_ADDR_STATUS    = 12'h0fe8;
	localparam logic [11:0] VJE_ADDR_POLARITY  = 12'h0fec;
	localparam logic [7:0]  VJE_CONTROL_RESET  = 8'h00;
	localparam logic [7:0]  VJE_CONTROL_WMASK  = 8'h1c;
	localparam int          VJE_BIT_SRC_SEL    = 4;
	localparam int          VJE_BIT_AUTO_FIELD = 3;
	localparam int          VJE_BIT_ELIM_EN    = 2;
	localparam int          VJE_BIT_FIELD      = 3;
	localparam int          VJE_BIT_HPOL       = 6;
	localparam int          VJE_LINE_W         = 12;
	localparam int          VJE_PHASE_STEPS    = 8;
	localparam logic [VJE_LINE_W-1:0] VJE_LINE_DEFAULT = 12'h0280;
	localparam logic [VJE_LINE_W-1:0] VJE_LINE_MIN     = 12'h0010;
	typedef enum logic [1:0] {
		VJE_IDLE    = 2'b00,
		VJE_WAIT_H  = 2'b01,
		VJE_PENDING = 2'b10
	} vje_state_t;
endpackage : vje_pkg

// ### core/vje_edge_det.sv
/*
 vje_edge_det: falling edge detector with optional inversion.
 assumes the input is already synchronous to clk_i.
*/
module vje_edge_det (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// signal
	input  wire logic sig_i,
	input  wire logic invert_i,
	output logic      fall_o
);
	logic lvl;
	logic prev_reg;
	logic prev_next;

	always_comb begin
		lvl       = sig_i ^ invert_i;
		prev_next = lvl;
		fall_o    = prev_reg & ~lvl;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_reg <= 1'b1;
		end else begin
			prev_reg <= prev_next;
		end
	end
endmodule : vje_edge_det

// ### core/vje_wb_regs.sv
/*
 vje_wb_regs: wishbone classic slave holding the jitter control and polarity registers.
 assumes single-cycle classic transfers; ack comes one cycle after the request.
*/
module vje_wb_regs
	import vje_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [11:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// register contents
	input  wire logic [7:0]  status_i,
	output logic [7:0]       control_o,
	output logic             hpol_o
);
	logic [7:0]  control_reg, control_next;
	logic        hpol_reg, hpol_next;
	logic        ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic        wr;

	always_comb begin
		ack_next     = cyc_i & stb_i & ~ack_reg;
		wr           = ack_next & we_i & sel_i[0];
		control_next = control_reg;
		hpol_next    = hpol_reg;
		dat_next     = dat_reg;
		if (wr && adr_i == VJE_ADDR_CONTROL) begin
			// low bits kept zero whatever is written
			control_next = dat_i[7:0] & VJE_CONTROL_WMASK;
		end
		if (wr && adr_i == VJE_ADDR_POLARITY) begin
			hpol_next = dat_i[VJE_BIT_HPOL];
		end
		if (ack_next && !we_i) begin
			case (adr_i)
				VJE_ADDR_CONTROL:  dat_next = {24'h00_0000, control_reg};
				VJE_ADDR_STATUS:   dat_next = {24'h00_0000, status_i};
				VJE_ADDR_POLARITY: dat_next = {24'h00_0000, 1'b0, hpol_reg, 6'h00};
				default:           dat_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_reg <= VJE_CONTROL_RESET;
			hpol_reg    <= 1'b0;
			ack_reg     <= 1'b0;
			dat_reg     <= 32'h0000_0000;
		end else begin
			control_reg <= control_next;
			hpol_reg    <= hpol_next;
			ack_reg     <= ack_next;
			dat_reg     <= dat_next;
		end
	end

	assign ack_o     = ack_reg;
	assign dat_o     = dat_reg;
	assign control_o = control_reg;
	assign hpol_o    = hpol_reg;
endmodule : vje_wb_regs

// ### core/vje_top.sv
/*
 vje_top: vertical sync jitter elimination and field decision for the display generator.
 assumes hsync/vsync inputs synchronous to clk_i and active-low pulses.
*/
module vje_top
	import vje_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [11:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// sync inputs
	input  wire logic        hsync_pulse_i,
	input  wire logic        external_vsync_pin_i,
	input  wire logic        alt_vsync_pulse_i,
	// display generator
	output logic             vsync_int_o,
	output logic             field_first_o,
	output logic             show_first_row_o,
	output logic             show_second_row_o
);
	logic [7:0]            control;
	logic                  hpol;
	logic [7:0]            status;
	logic                  elim_en, auto_field, src_sel;
	logic                  vsel, h_fall, v_fall;
	vje_state_t            state_reg, state_next;
	logic [VJE_LINE_W-1:0] hcnt_reg, hcnt_next;
	logic [VJE_LINE_W-1:0] hper_reg, hper_next;
	logic [VJE_LINE_W-1:0] vpos_reg, vpos_next;
	logic [2:0]            phase_reg, phase_next;
	logic                  field_reg, field_next;
	logic                  vout_reg, vout_next;
	logic [2:0]            vstretch_reg, vstretch_next;
	logic                  fire;
	logic [VJE_LINE_W-1:0] quarter;

	function automatic logic [2:0] phase_of(input logic [VJE_LINE_W-1:0] pos,
	                                        input logic [VJE_LINE_W-1:0] per);
		logic [VJE_LINE_W+2:0] scaled;
		scaled = {pos, 3'b000};
		if (per == '0) begin
			phase_of = 3'd0;
		end else begin
			phase_of = 3'(scaled / {3'b000, per});
		end
	endfunction : phase_of

	vje_wb_regs u_regs (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.cyc_i     (cyc_i),
		.stb_i     (stb_i),
		.we_i      (we_i),
		.adr_i     (adr_i),
		.sel_i     (sel_i),
		.dat_i     (dat_i),
		.dat_o     (dat_o),
		.ack_o     (ack_o),
		.status_i  (status),
		.control_o (control),
		.hpol_o    (hpol)
	);

	vje_edge_det u_hedge (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.sig_i    (hsync_pulse_i),
		.invert_i (hpol),
		.fall_o   (h_fall)
	);

	vje_edge_det u_vedge (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.sig_i    (vsel),
		.invert_i (1'b0),
		.fall_o   (v_fall)
	);

	always_comb begin
		elim_en    = control[VJE_BIT_ELIM_EN];
		auto_field = control[VJE_BIT_AUTO_FIELD];
		src_sel    = control[VJE_BIT_SRC_SEL];
		vsel       = src_sel ? alt_vsync_pulse_i : external_vsync_pin_i;
		quarter    = hper_reg >> 2;
		status     = {4'h0, field_reg, phase_reg};
	end

	// line length measurement and phase of each vertical edge
	always_comb begin
		hcnt_next  = (hcnt_reg == '1) ? hcnt_reg : hcnt_reg + 1'b1;
		hper_next  = hper_reg;
		vpos_next  = vpos_reg;
		phase_next = phase_reg;
		state_next = state_reg;
		fire       = 1'b0;
		if (h_fall) begin
			hcnt_next = '0;
			if (hcnt_reg >= VJE_LINE_MIN) begin
				hper_next = hcnt_reg + 1'b1;
			end
		end
		if (v_fall) begin
			vpos_next  = hcnt_reg;
			phase_next = phase_of(hcnt_reg, hper_reg);
		end
		case (state_reg)
			VJE_IDLE: begin
				if (v_fall) begin
					if (!elim_en) begin
						fire = 1'b1;
					end else if (hcnt_reg <= quarter) begin
						// just after h edge: snap to it
						fire = 1'b1;
					end else if (hcnt_reg + quarter >= hper_reg) begin
						// just before h edge: wait for it
						state_next = VJE_WAIT_H;
					end else begin
						fire = 1'b1;
					end
				end
			end
			VJE_WAIT_H: begin
				if (h_fall || hcnt_reg == '1) begin
					fire       = 1'b1;
					state_next = VJE_IDLE;
				end
			end
			default: state_next = VJE_IDLE;
		endcase
	end

	// internal vertical pulse from corrected syncs, field decision from the raw vertical edge position
	always_comb begin
		vstretch_next = vstretch_reg;
		vout_next     = vout_reg;
		field_next    = field_reg;
		if (fire) begin
			vstretch_next = 3'h7;
			vout_next     = 1'b0;
			// edge in first half of line marks the first dot row field
			// an immediate fire has not latched its own position yet
			if (auto_field) begin
				field_next = ((v_fall ? hcnt_reg : vpos_reg) < (hper_reg >> 1));
			end else begin
				field_next = 1'b0;
			end
		end else if (vstretch_reg != 3'h0) begin
			vstretch_next = vstretch_reg - 1'b1;
		end else begin
			vout_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg    <= VJE_IDLE;
			hcnt_reg     <= '0;
			hper_reg     <= VJE_LINE_DEFAULT;
			vpos_reg     <= '0;
			phase_reg    <= 3'h0;
			field_reg    <= 1'b0;
			vout_reg     <= 1'b1;
			vstretch_reg <= 3'h0;
		end else begin
			state_reg    <= state_next;
			hcnt_reg     <= hcnt_next;
			hper_reg     <= hper_next;
			vpos_reg     <= vpos_next;
			phase_reg    <= phase_next;
			field_reg    <= field_next;
			vout_reg     <= vout_next;
			vstretch_reg <= vstretch_next;
		end
	end

	always_comb begin
		vsync_int_o      = vout_reg;
		field_first_o    = field_reg;
		// second row always shown when enabled; first only in interlaced mode
		show_second_row_o = elim_en;
		show_first_row_o  = elim_en & auto_field & src_sel;
	end
endmodule : vje_top

// ### tb/vje_chk_assertions.sv
/* vje_chk: port assertions for vje_top.
   assumes one clock domain and a bind onto vje_top. */
module vje_chk
	import vje_pkg::*;
(
	// clock, reset, bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// syncs and display
	input wire logic        external_vsync_pin_i,
	input wire logic        alt_vsync_pulse_i,
	input wire logic        vsync_int_o,
	input wire logic        show_first_row_o,
	input wire logic        show_second_row_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ctl_reg;
	logic [7:0] ctl_next;
	logic       src_v;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// shadow control, updated at the edge that takes the write, as the slave does
	always_comb begin
		ctl_next = ctl_reg;
		if (cyc_i && stb_i && !ack_o && we_i && sel_i[0] && adr_i == VJE_ADDR_CONTROL) begin
			ctl_next = dat_i[7:0] & VJE_CONTROL_WMASK;
		end
	end
	always_ff @(posedge clk_i) begin
		ctl_reg <= rst_i ? VJE_CONTROL_RESET : ctl_next;
	end
	assign src_v = ctl_reg[VJE_BIT_SRC_SEL] ? alt_vsync_pulse_i : external_vsync_pin_i;
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_vlow;
		!vsync_int_o [*8] ##1 vsync_int_o;
	endsequence
	a_ack_follows: assert property (s_req |=> ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_read_ctrl: assert property (ack_o && !we_i && adr_i == VJE_ADDR_CONTROL |-> dat_o[7:0] == ctl_reg)
		else $error("control readback wrong");
	a_vint_width: assert property ($fell(vsync_int_o) |-> s_vlow)
		else $error("internal vsync not eight cycles");
	a_second_row: assert property (show_second_row_o == ctl_reg[VJE_BIT_ELIM_EN])
		else $error("second row not following enable");
	a_first_row: assert property (&ctl_reg[4:2] |-> show_first_row_o && show_second_row_o)
		else $error("interlaced rows not both shown");
	a_only_second: assert property (ctl_reg[4:2] == 3'b001 |-> !show_first_row_o)
		else $error("first row shown when non-interlaced");
	a_pass_thru: assert property (!ctl_reg[VJE_BIT_ELIM_EN] && $fell(vsync_int_o)
		|-> $past(src_v, 2) && !$past(src_v))
		else $error("internal vsync without selected pulse");
endmodule : vje_chk
bind vje_top vje_chk chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
	.external_vsync_pin_i, .alt_vsync_pulse_i, .vsync_int_o, .show_first_row_o, .show_second_row_o);

// ### tb/vje_sync_model.sv
/* vje_sync_model: signal processor stand-in, line sync and two vertical pulses.
   assumes fire is called from a process synchronous to clk_i. */
module vje_sync_model #(
	parameter int PERIOD = 64
) (
	// clock
	input  wire logic clk_i,
	// sync pulses, active low
	output logic      hsync_o,
	output logic      ext_vsync_o,
	output logic      alt_vsync_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial begin
		hsync_o = 1'b1;
		ext_vsync_o = 1'b1;
		alt_vsync_o = 1'b1;
	end
	// line low for 16 counts, so either edge can be the reference
	always @(posedge clk_i) begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		hsync_o <= (cnt >= 16);
	end
	task automatic fire(input int d, input logic alt);
		do @(posedge clk_i); while (cnt != 0);
		repeat (d) @(posedge clk_i);
		if (alt) begin
			alt_vsync_o <= 1'b0;
		end else begin
			ext_vsync_o <= 1'b0;
		end
		repeat (16) @(posedge clk_i);
		alt_vsync_o <= 1'b1;
		ext_vsync_o <= 1'b1;
	endtask : fire
endmodule : vje_sync_model

// ### tb/tb_top.sv
/* tb_top: register, source, phase, window and row tests for vje_top.
   assumes the sync model runs a 64 cycle line. */
module tb_top
	import vje_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [11:0] adr_i = 12'h0000;
	logic [3:0]  sel_i = 4'h1;
	logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
	logic        ack_o, hsync, ext_v, alt_v, vint, field, row1, row2, seen;
	int          err_count = 0, comparisons = 0, n;
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) if (vint === 1'b0) seen <= 1'b1;
	vje_top dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.hsync_pulse_i(hsync), .external_vsync_pin_i(ext_v), .alt_vsync_pulse_i(alt_v), .vsync_int_o(vint),
		.field_first_o(field), .show_first_row_o(row1), .show_second_row_o(row2));
	vje_sync_model sm_u (.clk_i, .hsync_o(hsync), .ext_vsync_o(ext_v), .alt_vsync_o(alt_v));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= {3'h0, s};
		dat_i <= {24'h00_0000, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	// cycles from the seen vertical edge to the internal pulse
	task automatic meas;
		n = 0;
		do @(posedge clk_i); while (ext_v !== 1'b0);
		do begin @(posedge clk_i); n++; end while (vint !== 1'b0 && n < 40);
	endtask : meas
	task automatic t_regs;
		wb(0, VJE_ADDR_CONTROL, 0, 1);
		chk("control reset", 0, rd);
		wb(1, VJE_ADDR_CONTROL, 8'h1c, 1);
		wb(1, VJE_ADDR_CONTROL, 8'h00, 0);
		wb(0, VJE_ADDR_CONTROL, 0, 1);
		chk("control bits", 32'h0000_001c, rd);
		wb(0, 12'h0f00, 0, 1);
		chk("unmapped", 0, rd);
		wb(0, VJE_ADDR_POLARITY, 0, 1);
		chk("polarity reset", 0, rd);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_rows;
		chk("both rows", 2'b11, {row1, row2});
		wb(1, VJE_ADDR_CONTROL, 8'h04, 1);
		chk("second row only", 2'b01, {row1, row2});
		wb(1, VJE_ADDR_CONTROL, 8'h00, 1);
		chk("rows off", 2'b00, {row1, row2});
		$display("t_rows done");
	endtask : t_rows
	task automatic t_src;
		seen <= 1'b0;
		sm_u.fire(20, 1);
		chk("alt ignored", 0, seen);
		wb(1, VJE_ADDR_CONTROL, 8'h10, 1);
		seen <= 1'b0;
		sm_u.fire(20, 1);
		chk("alt taken", 1, seen);
		$display("t_src done");
	endtask : t_src
	task automatic t_phase;
		wb(1, VJE_ADDR_CONTROL, 8'h08, 1);
		sm_u.fire(20, 0);
		wb(0, VJE_ADDR_STATUS, 0, 1);
		chk("status early", 4'b1010, rd[3:0]);
		sm_u.fire(44, 0);
		wb(0, VJE_ADDR_STATUS, 0, 1);
		chk("status late", 4'b0101, rd[3:0]);
		chk("field port", 0, field);
		wb(1, VJE_ADDR_CONTROL, 8'h00, 1);
		sm_u.fire(20, 0);
		chk("no auto field", 0, field);
		wb(1, VJE_ADDR_POLARITY, 8'h40, 1);
		sm_u.fire(20, 0);
		wb(0, VJE_ADDR_STATUS, 0, 1);
		chk("rising ref phase", 0, rd[2:0]);
		wb(1, VJE_ADDR_POLARITY, 8'h00, 1);
		$display("t_phase done");
	endtask : t_phase
	task automatic t_win;
		wb(1, VJE_ADDR_CONTROL, 8'h04, 1);
		fork sm_u.fire(56, 0); meas(); join
		chk("snapped", 1, n >= 8 && n <= 12);
		fork sm_u.fire(30, 0); meas(); join
		chk("outside window", 1, n <= 3);
		wb(1, VJE_ADDR_CONTROL, 8'h00, 1);
		fork sm_u.fire(56, 0); meas(); join
		chk("passed", 1, n <= 3);
		$display("t_win done");
	endtask : t_win
	task automatic summarize;
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	initial begin
		#(100 * 20000);
		err_count++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_rows();
		t_src();
		t_phase();
		t_win();
		summarize();
	end
endmodule : tb_top
